// ===== rtl/dbs_defines.svh
// Constants for the boot-security DMA request engine
`ifndef DBS_DEFINES_SVH
`define DBS_DEFINES_SVH
`define DBS_NUM_CH 8
`define DBS_NUM_REQ 8
`define DBS_MAX_RD_OUT 8
`define DBS_MAX_WR_OUT 8
`define DBS_FIFO_DEPTH 16
`define DBS_DATA_W 32
`define DBS_ADDR_W 32
`define DBS_LEN_W 16
`define DBS_OUT_W 4
`define DBS_REQ_UNUSED 7
`endif

// ===== rtl/dbs_engine.sv
// DMA engine core: boot security, channels, requests, master bus
// Notes on behaviour
// - Boot select low makes the manager secure, fed only from the secure port.
// - While secure, instructions from the non-secure port are dropped.
// - Boot select high makes the manager non-secure; both ports may steer.
// - There are eight independent channels.
// - Up to eight reads and eight writes may be outstanding at once.
// - Eight interrupt outputs report channel events.
// - Eight peripheral request inputs start transfers without the CPU.
// - Both memory-to-memory and memory-peripheral moves are supported.
`timescale 1ns/1ps
`default_nettype none
`include "dbs_defines.svh"
module dbs_engine (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic boot_security_select_i,
   input wire dbs_pkg::dbs_cmd_t sec_cmd_i,
   input wire dbs_pkg::dbs_cmd_t ns_cmd_i,
   input wire logic [`DBS_NUM_REQ-1:0] periph_req_i,
   output logic [`DBS_NUM_REQ-1:0] periph_ack_o,
   output logic mgr_nonsecure_o,
   output logic ns_cmd_dropped_o,
   output var dbs_pkg::dbs_areq_t rd_req_o,
   input wire logic rd_accept_i,
   input wire logic rd_valid_i,
   input wire logic [`DBS_DATA_W-1:0] rd_data_i,
   output var dbs_pkg::dbs_areq_t wr_req_o,
   output logic [`DBS_DATA_W-1:0] wr_data_o,
   input wire logic wr_accept_i,
   input wire logic wr_resp_i,
   output logic [`DBS_NUM_CH-1:0] irq_o,
   output logic [`DBS_NUM_CH-1:0] ch_busy_o
);
   // -------------------------------------------------------
   // Pin synchronisers and boot capture
   // -------------------------------------------------------
   logic [`DBS_NUM_REQ-1:0] req_m_ff;
   logic [`DBS_NUM_REQ-1:0] req_s_ff;
   logic [`DBS_NUM_REQ-1:0] req_d_ff;
   logic [`DBS_NUM_REQ-1:0] req_rise;
   logic boot_m_ff;
   logic boot_s_ff;
   logic boot_done_ff;
   // Request pins cross from peripheral logic; two flops before use
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         req_m_ff <= '0;
         req_s_ff <= '0;
         req_d_ff <= '0;
      end
      else
      begin
         req_m_ff <= periph_req_i;
         req_s_ff <= req_m_ff;
         req_d_ff <= req_s_ff;
      end
   end
   // Select sync runs through reset, so it already holds the static
   // select when reset lifts; a reset here would capture a stale zero
   always_ff @(posedge clk_i)
   begin
      boot_m_ff <= boot_security_select_i;
      boot_s_ff <= boot_m_ff;
   end
   assign req_rise = req_s_ff & ~req_d_ff;
   // Security state latched once after reset release; later changes ignored
   // since the select is only legal to move under reset
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         boot_done_ff <= 1'b0;
         mgr_nonsecure_o <= 1'b0; // secure until sampled
      end
      else if (!boot_done_ff)
      begin
         boot_done_ff <= 1'b1;
         mgr_nonsecure_o <= boot_s_ff;
      end
   end
   // -------------------------------------------------------
   // Port selection
   // -------------------------------------------------------
   dbs_pkg::dbs_cmd_t cmd;
   logic ns_ok;
   // Secure port always wins a tie; non-secure only when manager is NS
   assign ns_ok = boot_done_ff && mgr_nonsecure_o;
   always_comb
   begin
      if (sec_cmd_i.valid)
         cmd = sec_cmd_i;
      else if (ns_cmd_i.valid && ns_ok)
         cmd = ns_cmd_i;
      else
         cmd = '0;
   end
   // Flag a non-secure instruction dropped while secure, for one cycle
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         ns_cmd_dropped_o <= 1'b0;
      else
         ns_cmd_dropped_o <= ns_cmd_i.valid && !ns_ok;
   end
   // -------------------------------------------------------
   // Channel state
   // -------------------------------------------------------
   dbs_pkg::dbs_chst_t st_ff [`DBS_NUM_CH];
   logic [`DBS_ADDR_W-1:0] src_ff [`DBS_NUM_CH];
   logic [`DBS_ADDR_W-1:0] dst_ff [`DBS_NUM_CH];
   logic [`DBS_LEN_W-1:0] rem_ff [`DBS_NUM_CH];
   logic [`DBS_LEN_W-1:0] wrem_ff [`DBS_NUM_CH];
   logic [`DBS_NUM_CH-1:0] m2m_ff;
   logic [`DBS_NUM_CH-1:0] armed_ff;
   logic [2:0] per_ff [`DBS_NUM_CH];
   logic [`DBS_NUM_CH-1:0] want_rd;
   logic [`DBS_NUM_CH-1:0] rd_go;
   logic [`DBS_NUM_CH-1:0] wr_go;
   logic [`DBS_NUM_CH-1:0] done;
   logic [2:0] rd_sel;
   logic [2:0] wr_owner;
   logic rd_issue;
   logic wr_issue;
   logic [`DBS_OUT_W-1:0] rd_out_ff;
   logic [`DBS_OUT_W-1:0] wr_out_ff;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [`DBS_DATA_W-1:0] fifo_out_data;
   // Owner tags of reads in flight, popped in issue order
   logic [2:0] tag_ff [`DBS_MAX_RD_OUT];
   logic [2:0] tag_wp_ff;
   logic [2:0] tag_rp_ff;
   // Owners travel with the request, since the arbiter may move on
   logic [2:0] rd_own_ff;
   logic [2:0] wr_own_ff;
   logic [4:0] held_ff;
   logic rd_room;
   // Each channel runs on its own; peripheral channels wait for a request
   for (genvar c = 0; c < `DBS_NUM_CH; c++)
   begin : g_ch
      assign want_rd[c] = (st_ff[c] == dbs_pkg::DBS_RUN) &&
         (rem_ff[c] != '0) && (m2m_ff[c] || armed_ff[c]);
      assign done[c] = (st_ff[c] == dbs_pkg::DBS_RUN) &&
         (wrem_ff[c] == '0) && (rem_ff[c] == '0);
      assign rd_go[c] = rd_issue && (rd_own_ff == 3'(c));
      assign wr_go[c] = wr_issue && (wr_own_ff == 3'(c));
      always_ff @(posedge clk_i)
      begin
         if (!resetn_i)
         begin
            st_ff[c] <= dbs_pkg::DBS_IDLE;
            src_ff[c] <= '0;
            dst_ff[c] <= '0;
            rem_ff[c] <= '0;
            wrem_ff[c] <= '0;
            m2m_ff[c] <= 1'b0;
            armed_ff[c] <= 1'b0;
            per_ff[c] <= '0;
            irq_o[c] <= 1'b0;
            ch_busy_o[c] <= 1'b0;
         end
         else
         begin
            irq_o[c] <= 1'b0;
            case (st_ff[c])
               dbs_pkg::DBS_IDLE:
               begin
                  if (cmd.valid && cmd.chan == 3'(c) && cmd.len != '0)
                  begin
                     st_ff[c] <= dbs_pkg::DBS_RUN;
                     src_ff[c] <= cmd.src;
                     dst_ff[c] <= cmd.dst;
                     rem_ff[c] <= cmd.len;
                     wrem_ff[c] <= cmd.len;
                     m2m_ff[c] <= cmd.mem2mem;
                     per_ff[c] <= cmd.periph;
                     ch_busy_o[c] <= 1'b1;
                     armed_ff[c] <= 1'b0;
                  end
               end
               dbs_pkg::DBS_RUN:
               begin
                  // Request edge arms one word and wins over the issue that disarms; any other edge while still armed is lost
                  if (req_rise[per_ff[c]] && !m2m_ff[c])
                     armed_ff[c] <= 1'b1;
                  else if (rd_go[c])
                     armed_ff[c] <= 1'b0;
                  if (rd_go[c])
                  begin
                     src_ff[c] <= src_ff[c] + 32'h4;
                     rem_ff[c] <= rem_ff[c] - 16'h1;
                  end
                  if (wr_go[c])
                  begin
                     dst_ff[c] <= dst_ff[c] + 32'h4;
                     wrem_ff[c] <= wrem_ff[c] - 16'h1;
                  end
                  if (done[c])
                  begin
                     st_ff[c] <= dbs_pkg::DBS_IDLE;
                     irq_o[c] <= 1'b1;
                     ch_busy_o[c] <= 1'b0;
                  end
               end
               default: st_ff[c] <= dbs_pkg::DBS_IDLE;
            endcase
         end
      end
   end
   // -------------------------------------------------------
   // Read issue: fixed priority, capped by outstanding limit
   // -------------------------------------------------------
   always_comb
   begin
      rd_sel = '0;
      for (int i = `DBS_NUM_CH - 1; i >= 0; i--)
         if (want_rd[i])
            rd_sel = 3'(i);
   end
   // Reads also count against FIFO room so words never overflow
   assign rd_issue = rd_req_o.valid && rd_accept_i;
   assign rd_room = (6'(held_ff) + 6'(rd_out_ff)) < 6'(`DBS_FIFO_DEPTH);
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         rd_req_o <= '0;
         rd_own_ff <= '0;
      end
      else if (!rd_req_o.valid || rd_accept_i)
      begin
         rd_req_o.valid <= (want_rd != '0) && !rd_issue &&
            (rd_out_ff < `DBS_OUT_W'(`DBS_MAX_RD_OUT)) &&
            fifo_in_ready && rd_room;
         rd_req_o.addr <= src_ff[rd_sel];
         rd_own_ff <= rd_sel;
      end
   end
   // Outstanding reads and owner tags
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         rd_out_ff <= '0;
         tag_wp_ff <= '0;
         tag_rp_ff <= '0;
      end
      else
      begin
         rd_out_ff <= rd_out_ff + `DBS_OUT_W'(rd_issue) -
            `DBS_OUT_W'(rd_valid_i);
         if (rd_issue)
         begin
            tag_ff[tag_wp_ff] <= rd_own_ff;
            tag_wp_ff <= tag_wp_ff + 3'h1;
         end
         if (rd_valid_i)
            tag_rp_ff <= tag_rp_ff + 3'h1;
      end
   end
   // -------------------------------------------------------
   // Data buffer between read and write side
   // -------------------------------------------------------
   logic [`DBS_DATA_W+2:0] fifo_in;
   logic [`DBS_DATA_W+2:0] fifo_out;
   assign fifo_in = {tag_ff[tag_rp_ff], rd_data_i};
   dbs_fifo #(
      .WIDTH(`DBS_DATA_W + 3),
      .DEPTH(`DBS_FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(rd_valid_i),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out)
   );
   assign fifo_out_data = fifo_out[`DBS_DATA_W-1:0];
   assign wr_owner = fifo_out[`DBS_DATA_W+2:`DBS_DATA_W];
   // -------------------------------------------------------
   // Write issue, capped by outstanding limit
   // -------------------------------------------------------
   assign wr_issue = wr_req_o.valid && wr_accept_i;
   assign fifo_out_ready = !wr_req_o.valid &&
      (wr_out_ff < `DBS_OUT_W'(`DBS_MAX_WR_OUT));
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         wr_req_o <= '0;
         wr_data_o <= '0;
         wr_own_ff <= '0;
      end
      else if (fifo_out_valid && fifo_out_ready)
      begin
         wr_req_o.valid <= 1'b1;
         wr_req_o.addr <= dst_ff[wr_owner];
         wr_own_ff <= wr_owner;
         wr_data_o <= fifo_out_data;
      end
      else if (wr_accept_i)
         wr_req_o.valid <= 1'b0;
   end
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         wr_out_ff <= '0;
      else
         wr_out_ff <= wr_out_ff + `DBS_OUT_W'(wr_issue) -
            `DBS_OUT_W'(wr_resp_i);
   end
   // Words held in the buffer; with reads in flight it bounds the fill
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         held_ff <= '0;
      else
         held_ff <= held_ff + 5'(rd_valid_i) -
            5'(fifo_out_valid && fifo_out_ready);
   end
   // Acknowledge the peripheral when its word is read
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         periph_ack_o <= '0;
      else
         for (int p = 0; p < `DBS_NUM_REQ; p++)
            periph_ack_o[p] <= rd_issue && !m2m_ff[rd_own_ff] &&
               per_ff[rd_own_ff] == 3'(p);
   end
   // -------------------------------------------------------
   // Checks
   // -------------------------------------------------------
   chk_rd_limit: assert property (@(posedge clk_i) disable iff (!resetn_i)
      rd_out_ff <= `DBS_OUT_W'(`DBS_MAX_RD_OUT))
      else $error("too many reads outstanding");
   chk_wr_limit: assert property (@(posedge clk_i) disable iff (!resetn_i)
      wr_out_ff <= `DBS_OUT_W'(`DBS_MAX_WR_OUT))
      else $error("too many writes outstanding");
   chk_ns_drop: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ns_cmd_i.valid && !sec_cmd_i.valid && boot_done_ff &&
      !mgr_nonsecure_o |-> !cmd.valid)
      else $error("non-secure command taken while secure");
   chk_boot_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
      boot_done_ff && $past(boot_done_ff) |-> $stable(mgr_nonsecure_o))
      else $error("security state moved after boot");
   chk_boot_pick: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !boot_done_ff |=> mgr_nonsecure_o == $past(boot_s_ff))
      else $error("security state not taken from select");
   chk_ns_take: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ns_cmd_i.valid && !sec_cmd_i.valid && ns_ok |-> cmd.valid)
      else $error("non-secure command lost while non-secure");
   chk_irq_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i)
      |irq_o |=> (irq_o & $past(irq_o)) == '0)
      else $error("interrupt longer than a pulse");
   chk_dropped_flag: assert property (@(posedge clk_i)
      disable iff (!resetn_i)
      ns_cmd_i.valid && !ns_ok |=> ns_cmd_dropped_o)
      else $error("drop not flagged");
   chk_buf_room: assert property (@(posedge clk_i) disable iff (!resetn_i)
      rd_valid_i |-> fifo_in_ready)
      else $error("read word arrived with buffer full");
endmodule // dbs_engine
`default_nettype wire

// ===== rtl/dbs_fifo.sv
// Small synchronous FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module dbs_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wp_ff;
   logic [AW:0] rp_ff;
   logic [AW:0] cnt;
   logic push;
   logic pop;
   // -------------------------------------------------------
   // Occupancy
   // -------------------------------------------------------
   assign cnt = wp_ff - rp_ff;
   assign in_ready_o = (cnt != (AW+1)'(DEPTH));
   assign push = in_valid_i && in_ready_o;
   // Output register refills when empty or consumed
   assign pop = (cnt != '0) && (!out_valid_o || out_ready_i);
   // Pointers
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         wp_ff <= '0;
         rp_ff <= '0;
      end
      else
      begin
         if (push)
            wp_ff <= wp_ff + 1'b1;
         if (pop)
            rp_ff <= rp_ff + 1'b1;
      end
   end
   // Storage
   always_ff @(posedge clk_i)
   begin
      if (push)
         mem_ff[wp_ff[AW-1:0]] <= in_data_i;
   end
   // Registered read side
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
      end
      else if (pop)
      begin
         out_valid_o <= 1'b1;
         out_data_o <= mem_ff[rp_ff[AW-1:0]];
      end
      else if (out_ready_i)
         out_valid_o <= 1'b0;
   end
endmodule // dbs_fifo
`default_nettype wire

// ===== rtl/dbs_pkg.sv
// Types shared by the boot-security DMA request engine
`include "dbs_defines.svh"
package dbs_pkg;
   typedef struct packed
   {
      logic valid;
      logic [2:0] chan;
      logic mem2mem;
      logic [2:0] periph;
      logic [`DBS_ADDR_W-1:0] src;
      logic [`DBS_ADDR_W-1:0] dst;
      logic [`DBS_LEN_W-1:0] len;
   } dbs_cmd_t;
   typedef enum logic [1:0] {DBS_IDLE, DBS_RUN} dbs_chst_t;
   typedef struct packed
   {
      logic valid;
      logic [`DBS_ADDR_W-1:0] addr;
   } dbs_areq_t;
endpackage

// ===== verif/dbs_mem_model.sv
// Memory and interconnect slave model for the engine's master bus
`timescale 1ns/1ps
`default_nettype none
`include "dbs_defines.svh"
module dbs_mem_model (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic slow_i,
   input wire dbs_pkg::dbs_areq_t rd_req_i,
   output logic rd_accept_o,
   output logic rd_valid_o,
   output logic [`DBS_DATA_W-1:0] rd_data_o,
   input wire dbs_pkg::dbs_areq_t wr_req_i,
   input wire logic [`DBS_DATA_W-1:0] wr_data_i,
   output logic wr_accept_o,
   output logic wr_resp_o,
   output logic [7:0] max_rd_o,
   output logic [7:0] max_wr_o
);
   logic [`DBS_DATA_W-1:0] mem [0:255];
   logic [`DBS_DATA_W-1:0] rd_q [$];
   int rd_due [$];
   int wr_due [$];
   int cyc = 0;
   int rd_out = 0;
   int wr_out = 0;
   logic tick_ff = 1'b0;

   // Slow mode takes a request only every other cycle, so holds are tested,
   // and answers late enough that the outstanding limits are reached
   assign rd_accept_o = rd_req_i.valid && (!slow_i || tick_ff);
   assign wr_accept_o = wr_req_i.valid && (!slow_i || tick_ff);

   // Reads return in issue order; idle data lines show a changing pattern
   always @(posedge clk_i)
   begin
      cyc = cyc + 1;
      tick_ff <= ~tick_ff;
      if (!resetn_i)
      begin
         rd_q.delete();
         rd_due.delete();
         wr_due.delete();
         rd_out = 0;
         wr_out = 0;
         max_rd_o <= 8'h00;
         max_wr_o <= 8'h00;
         rd_valid_o <= 1'b0;
         wr_resp_o <= 1'b0;
         rd_data_o <= 32'h0000_0000;
      end
      else
      begin
         rd_valid_o <= 1'b0;
         rd_data_o <= ~rd_data_o;
         if (rd_due.size() > 0 && rd_due[0] <= cyc)
         begin
            rd_valid_o <= 1'b1;
            rd_data_o <= rd_q.pop_front();
            void'(rd_due.pop_front());
            rd_out = rd_out - 1;
         end
         if (rd_accept_o)
         begin
            rd_q.push_back(mem[rd_req_i.addr[9:2]]);
            rd_due.push_back(cyc + (slow_i ? 40 : 2));
            rd_out = rd_out + 1;
         end
         wr_resp_o <= 1'b0;
         if (wr_due.size() > 0 && wr_due[0] <= cyc)
         begin
            wr_resp_o <= 1'b1;
            void'(wr_due.pop_front());
            wr_out = wr_out - 1;
         end
         if (wr_accept_o)
         begin
            mem[wr_req_i.addr[9:2]] = wr_data_i;
            wr_due.push_back(cyc + (slow_i ? 40 : 2));
            wr_out = wr_out + 1;
         end
         if (rd_out > max_rd_o)
            max_rd_o <= 8'(rd_out);
         if (wr_out > max_wr_o)
            max_wr_o <= 8'(wr_out);
      end
   end
endmodule // dbs_mem_model
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the boot-security DMA engine
`timescale 1ns/1ps
`default_nettype none
`include "dbs_defines.svh"
module tb;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic sel = 1'b0;
   logic slow = 1'b0;
   logic [7:0] preq = 8'h00; // Line seven stays low throughout
   dbs_pkg::dbs_cmd_t sec_cmd = '0;
   dbs_pkg::dbs_cmd_t ns_cmd = '0;
   dbs_pkg::dbs_areq_t rd_req, wr_req;
   logic [7:0] ack, irq, busy, max_rd, max_wr;
   logic mgr_ns, dropped, rd_acc, rd_val, wr_acc, wr_resp;
   logic [31:0] rd_data, wr_data;
   logic [7:0] seen_irq, seen_ack, seen_busy;
   logic seen_drop;
   int err_count = 0;
   int samples_checked = 0;

   always #5 clk_i = ~clk_i;

   dbs_engine dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
      .boot_security_select_i(sel), .sec_cmd_i(sec_cmd), .ns_cmd_i(ns_cmd),
      .periph_req_i(preq), .periph_ack_o(ack), .mgr_nonsecure_o(mgr_ns),
      .ns_cmd_dropped_o(dropped), .rd_req_o(rd_req), .rd_accept_i(rd_acc),
      .rd_valid_i(rd_val), .rd_data_i(rd_data), .wr_req_o(wr_req),
      .wr_data_o(wr_data), .wr_accept_i(wr_acc), .wr_resp_i(wr_resp),
      .irq_o(irq), .ch_busy_o(busy));
   dbs_mem_model mem_u (.clk_i(clk_i), .resetn_i(resetn_i), .slow_i(slow),
      .rd_req_i(rd_req), .rd_accept_o(rd_acc), .rd_valid_o(rd_val),
      .rd_data_o(rd_data), .wr_req_i(wr_req), .wr_data_i(wr_data),
      .wr_accept_o(wr_acc), .wr_resp_o(wr_resp), .max_rd_o(max_rd),
      .max_wr_o(max_wr));

   function automatic logic [31:0] pat(input int i);
      return 32'h5a00_0000 + 32'(i);
   endfunction

   // Every step lands just after the edge and gathers the one-cycle pulses
   task automatic step;
      @(posedge clk_i);
      #1;
      seen_irq = seen_irq | irq;
      seen_ack = seen_ack | ack;
      seen_busy = seen_busy | busy;
      seen_drop = seen_drop | dropped;
   endtask
   task automatic clear;
      seen_irq = 8'h00;
      seen_ack = 8'h00;
      seen_busy = 8'h00;
      seen_drop = 1'b0;
   endtask
   task automatic cmp_bit(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e)
      begin
         err_count++;
         $display("Error %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic cmp_word(input string n, input logic [31:0] e,
      input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic copy_ok(input int s, input int d, input int n);
      for (int i = 0; i < n; i++)
         cmp_word("copied_word", pat(s + i), mem_u.mem[d + i]);
   endtask
   // The select moves only while reset is held
   task automatic do_reset(input logic s);
      resetn_i = 1'b0;
      sel = s;
      repeat (2) step;
      resetn_i = 1'b1;
      repeat (4) step;
      cmp_bit("mgr_nonsecure", s, mgr_ns);
   endtask
   // A command is a one-cycle pulse; a spare edge follows before the next
   task automatic send(input logic ns, input int ch, m2m, p, s, d, n);
      dbs_pkg::dbs_cmd_t c;
      c = '0;
      c.valid = 1'b1;
      c.chan = 3'(ch);
      c.mem2mem = 1'(m2m);
      c.periph = 3'(p);
      c.src = 32'(s * 4);
      c.dst = 32'(d * 4);
      c.len = 16'(n);
      if (ns)
         ns_cmd = c;
      else
         sec_cmd = c;
      step;
      sec_cmd = '0;
      ns_cmd = '0;
      step;
   endtask
   task automatic wait_mask(input logic [7:0] want, input int lim);
      for (int i = 0; i < lim; i++)
      begin
         if (want != 8'h00 && (seen_irq & want) == want)
            break;
         step;
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_nonsec;
      do_reset(1'b1);
      clear;
      send(1'b1, 1, 1, 0, 8, 96, 2);
      wait_mask(8'h02, 300);
      cmp_word("irq_seen", 32'h02, 32'(seen_irq));
      cmp_bit("ns_dropped", 1'b0, seen_drop);
      copy_ok(8, 96, 2);
      clear;
      send(1'b0, 2, 1, 0, 12, 100, 1);
      wait_mask(8'h04, 300);
      cmp_word("irq_seen", 32'h04, 32'(seen_irq));
      copy_ok(12, 100, 1);
   endtask
   task automatic t_secure;
      do_reset(1'b0);
      clear;
      send(1'b1, 0, 1, 0, 0, 64, 3);
      wait_mask(8'h00, 20);
      cmp_bit("ns_dropped", 1'b1, seen_drop);
      cmp_word("busy_seen", 32'h00, 32'(seen_busy));
      cmp_word("mem_untouched", pat(64), mem_u.mem[64]);
      clear;
      send(1'b0, 0, 1, 0, 0, 64, 3);
      wait_mask(8'h01, 300);
      cmp_word("irq_seen", 32'h01, 32'(seen_irq));
      copy_ok(0, 64, 3);
      step;
      cmp_word("busy", 32'h00, 32'(busy));
   endtask
   // All channels at once against a slow bus, to pile up outstanding work
   task automatic t_all;
      slow = 1'b1;
      clear;
      for (int ch = 0; ch < 8; ch++)
         send(1'b0, ch, 1, 0, 16 + ch * 4, 128 + ch * 4, 4);
      wait_mask(8'hff, 3000);
      cmp_word("irq_seen", 32'hff, 32'(seen_irq));
      for (int ch = 0; ch < 8; ch++)
         copy_ok(16 + ch * 4, 128 + ch * 4, 4);
      cmp_word("rd_outstanding_max", 32'h08, 32'(max_rd));
      cmp_word("wr_outstanding_max", 32'h08, 32'(max_wr));
      slow = 1'b0;
   endtask
   // Sources 0 to 6 each start their own channel; nothing moves before it asks
   task automatic t_periph;
      for (int p = 0; p < 7; p++)
      begin
         clear;
         send(1'b0, p, 0, p, 48 + p, 192 + p, 1);
         wait_mask(8'h00, 10);
         cmp_word("irq_early", 32'h00, 32'(seen_irq));
         preq[p] = 1'b1;
         wait_mask(8'h01 << p, 300);
         preq[p] = 1'b0;
         cmp_word("ack_seen", 32'h01 << p, 32'(seen_ack));
         cmp_word("irq_seen", 32'h01 << p, 32'(seen_irq));
         copy_ok(48 + p, 192 + p, 1);
      end
   endtask
   // A copy longer than the buffer, on a slow bus, streams through in order
   task automatic t_fifo;
      slow = 1'b1;
      clear;
      send(1'b0, 3, 1, 0, 160, 200, 20);
      wait_mask(8'h08, 1000);
      cmp_word("irq_seen", 32'h08, 32'(seen_irq));
      copy_ok(160, 200, 20);
      step;
      cmp_word("busy", 32'h00, 32'(busy));
      slow = 1'b0;
   endtask

   task automatic conclude;
      $display("Checked %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      clear;
      for (int i = 0; i < 256; i++)
         mem_u.mem[i] = pat(i);
      t_nonsec;
      t_secure;
      t_all;
      t_periph;
      t_fifo;
      conclude;
   end
   // Whole run is well under a thousand cycles; this, 40000 cycles, is far beyond it
   initial
   begin
      #400000;
      err_count++;
      conclude;
   end
endmodule // tb
`default_nettype wire
